// >>> inc/emp_pkg.sv
package emp_pkg;

    // Register map
    localparam logic [7:0] EMP_REG_STATUS = 8'hA0;
    localparam logic [7:0] EMP_REG_TIMING = 8'hA1;
    localparam logic [7:0] EMP_REG_PAGE   = 8'hA2;
    localparam logic [7:0] EMP_REG_CFG    = 8'hA3;

    // Reset values
    localparam logic [7:0] EMP_PAGE_RST   = 8'h00;
    localparam logic [7:0] EMP_CFG_RST    = 8'h03;
    localparam logic [7:0] EMP_TIMING_RST = 8'hFF;

    // Config field positions
    localparam int EMP_CFG_PINMAP_BIT = 5;
    localparam int EMP_CFG_MUXSEL_BIT = 4;
    localparam int EMP_CFG_MODE_LSB   = 2;
    localparam int EMP_CFG_ALEW_LSB   = 0;
    localparam logic [7:0] EMP_CFG_WMASK = 8'h3F;

    // Timing field positions
    localparam int EMP_TIM_SETUP_LSB = 6;
    localparam int EMP_TIM_WIDTH_LSB = 2;
    localparam int EMP_TIM_HOLD_LSB  = 0;

    // Status bit positions
    localparam int EMP_STS_BUSY_BIT    = 0;
    localparam int EMP_STS_OFFCHIP_BIT = 1;

    // On-chip space
    localparam int                EMP_ONCHIP_AW    = 12;
    localparam logic [15:0]       EMP_ONCHIP_LIMIT = 16'h1000;

    // Fixed off-chip overhead: one start cycle plus end cycles
    localparam int                EMP_OVERHEAD_CYC = 4;
    localparam logic [3:0]        EMP_END_LOAD     = 4'(EMP_OVERHEAD_CYC - 2);

    // Pin positions on the control port
    localparam int EMP_P4_WR_BIT  = 7;
    localparam int EMP_P4_RD_BIT  = 6;
    localparam int EMP_P4_ALE_BIT = 5;

    typedef enum logic [1:0] {
        EMP_MODE_INTERNAL = 2'h0,
        EMP_MODE_SPLIT    = 2'h1,
        EMP_MODE_BANK     = 2'h2,
        EMP_MODE_EXTERNAL = 2'h3
    } emp_mode_t;

endpackage

// >>> rtl/emp_sync.sv
`timescale 1ns/1ps
module emp_sync #(
    parameter int W = 8
) (
    input  wire logic         mclk_i,
    input  wire logic         resetn_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// >>> rtl/emp_ram.sv
`timescale 1ns/1ps
module emp_ram #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input  wire logic          mclk_i,
    input  wire logic          en_i,
    input  wire logic          wr_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] wdata_i,
    output logic      [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge mclk_i) begin
        if (en_i) begin
            if (wr_i) begin
                mem[addr_i] <= wdata_i;
            end
            rdata_o <= mem[addr_i];
        end
    end
endmodule

// >>> rtl/emp_port_modes.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module emp_port_modes
    import emp_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // Core external-move access
    input  wire logic        ext_move_req_i,
    input  wire logic        ext_move_wr_i,
    input  wire logic        ext_move_wide_i,
    input  wire logic [15:0] wide_pointer_i,
    input  wire logic [7:0]  index_register_i,
    input  wire logic [7:0]  ext_move_wdata_i,
    output logic      [7:0]  ext_move_rdata_o,
    output logic             ext_move_done_o,
    // Port latches
    input  wire logic [7:0]  p4_latch_i,
    input  wire logic [7:0]  p5_latch_i,
    input  wire logic [7:0]  p6_latch_i,
    input  wire logic [7:0]  p7_latch_i,
    // Pins
    input  wire logic [7:0]  p7_pin_i,
    output logic      [7:0]  p4_out_o,
    output logic      [7:0]  p4_oe_o,
    output logic      [7:0]  p5_out_o,
    output logic      [7:0]  p5_oe_o,
    output logic      [7:0]  p6_out_o,
    output logic      [7:0]  p6_oe_o,
    output logic      [7:0]  p7_out_o,
    output logic      [7:0]  p7_oe_o
);
    typedef enum logic [8:0] {
        ST_IDLE   = 9'h001,
        ST_ONCHIP = 9'h002,
        ST_START  = 9'h004,
        ST_ALEH   = 9'h008,
        ST_ALEL   = 9'h010,
        ST_SETUP  = 9'h020,
        ST_STROBE = 9'h040,
        ST_HOLD   = 9'h080,
        ST_END    = 9'h100
    } emp_state_t;

    logic [7:0]  page_q;
    logic [7:0]  cfg_q;
    logic [7:0]  timing_q;
    logic        last_off_q;
    emp_state_t  state_q;
    logic [3:0]  cnt_q;
    logic        wr_q;
    logic        drive_hi_q;
    logic [15:0] addr_q;
    logic [7:0]  wdata_q;
    logic [7:0]  data_sync;
    logic [7:0]  ram_rdata;

    emp_mode_t   mode;
    logic        pin_map;
    logic        muxed;
    logic [3:0]  ale_len;
    logic [1:0]  setup_len;
    logic [3:0]  width_len;
    logic [1:0]  hold_len;
    logic [15:0] eff_addr;
    logic        off_chip;
    logic        start;
    logic        active;
    logic        claim;

    assign mode      = emp_mode_t'(cfg_q[EMP_CFG_MODE_LSB +: 2]);
    assign pin_map   = cfg_q[EMP_CFG_PINMAP_BIT];
    assign muxed     = !cfg_q[EMP_CFG_MUXSEL_BIT];
    assign ale_len   = {2'h0, cfg_q[EMP_CFG_ALEW_LSB +: 2]};
    assign setup_len = timing_q[EMP_TIM_SETUP_LSB +: 2];
    assign width_len = timing_q[EMP_TIM_WIDTH_LSB +: 4];
    assign hold_len  = timing_q[EMP_TIM_HOLD_LSB +: 2];
    assign start     = ext_move_req_i && (state_q == ST_IDLE);

    // Effective address: wide pointer or page plus index
    assign eff_addr = ext_move_wide_i ? wide_pointer_i
                                      : {page_q, index_register_i};

    always_comb begin
        unique case (mode)
            EMP_MODE_INTERNAL: off_chip = 1'b0;
            EMP_MODE_EXTERNAL: off_chip = 1'b1;
            default:           off_chip = eff_addr >= EMP_ONCHIP_LIMIT;
        endcase
    end

    assign active = !(state_q inside {ST_IDLE, ST_ONCHIP});
    assign claim  = active && pin_map;

    // Register writes
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            page_q   <= EMP_PAGE_RST;
            cfg_q    <= EMP_CFG_RST;
            timing_q <= EMP_TIMING_RST;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                EMP_REG_PAGE:   page_q   <= reg_wdata_i;
                EMP_REG_CFG:    cfg_q    <= reg_wdata_i & EMP_CFG_WMASK;
                EMP_REG_TIMING: timing_q <= reg_wdata_i;
                default:        ;
            endcase
        end
    end

    // Register reads, one cycle later
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                EMP_REG_PAGE:   reg_rdata_o <= page_q;
                EMP_REG_CFG:    reg_rdata_o <= cfg_q;
                EMP_REG_TIMING: reg_rdata_o <= timing_q;
                EMP_REG_STATUS: reg_rdata_o <= {6'h00, last_off_q, active};
                default:        reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // Access capture
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_q       <= 1'b0;
            drive_hi_q <= 1'b0;
            addr_q     <= 16'h0000;
            wdata_q    <= 8'h00;
            last_off_q <= 1'b0;
        end else if (start) begin
            wr_q       <= ext_move_wr_i;
            addr_q     <= eff_addr;
            wdata_q    <= ext_move_wdata_i;
            last_off_q <= off_chip;
            // Upper byte driven for wide pointer or bank select only
            drive_hi_q <= ext_move_wide_i || (mode == EMP_MODE_BANK);
        end
    end

    // Access sequencer
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            cnt_q   <= 4'h0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        state_q <= off_chip ? ST_START : ST_ONCHIP;
                    end
                end
                ST_ONCHIP: state_q <= ST_IDLE;
                ST_START: begin
                    if (muxed) begin
                        state_q <= ST_ALEH;
                        cnt_q   <= ale_len;
                    end else if (setup_len != 2'h0) begin
                        state_q <= ST_SETUP;
                        cnt_q   <= {2'h0, setup_len - 2'h1};
                    end else begin
                        state_q <= ST_STROBE;
                        cnt_q   <= width_len;
                    end
                end
                ST_ALEH: begin
                    if (cnt_q == 4'h0) begin
                        state_q <= ST_ALEL;
                        cnt_q   <= ale_len;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                ST_ALEL, ST_SETUP: begin
                    if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else if (state_q == ST_ALEL && setup_len != 2'h0) begin
                        state_q <= ST_SETUP;
                        cnt_q   <= {2'h0, setup_len - 2'h1};
                    end else begin
                        state_q <= ST_STROBE;
                        cnt_q   <= width_len;
                    end
                end
                ST_STROBE: begin
                    if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else if (hold_len != 2'h0) begin
                        state_q <= ST_HOLD;
                        cnt_q   <= {2'h0, hold_len - 2'h1};
                    end else begin
                        state_q <= ST_END;
                        cnt_q   <= EMP_END_LOAD;
                    end
                end
                ST_HOLD: begin
                    if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else begin
                        state_q <= ST_END;
                        cnt_q   <= EMP_END_LOAD;
                    end
                end
                ST_END: begin
                    if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // On-chip RAM, address aliased to its size
    emp_ram #(
        .AW (EMP_ONCHIP_AW),
        .DW (8)
    ) u_ram (
        .mclk_i  (mclk_i),
        .en_i    (start && !off_chip),
        .wr_i    (ext_move_wr_i),
        .addr_i  (eff_addr[EMP_ONCHIP_AW-1:0]),
        .wdata_i (ext_move_wdata_i),
        .rdata_o (ram_rdata)
    );

    emp_sync #(
        .W (8)
    ) u_data_sync (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .async_i  (p7_pin_i),
        .sync_o   (data_sync)
    );

    // Last read-strobe pin cycle reaches the synchroniser output two cycles later
    logic [2:0] rd_pipe_q;

    // Completion and read data
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ext_move_done_o  <= 1'b0;
            ext_move_rdata_o <= 8'h00;
            rd_pipe_q        <= 3'h0;
        end else begin
            ext_move_done_o <= (state_q == ST_ONCHIP) ||
                               (state_q == ST_END && cnt_q == 4'h0);
            rd_pipe_q <= {rd_pipe_q[1:0], state_q == ST_STROBE && cnt_q == 4'h0 && !wr_q};
            if (state_q == ST_ONCHIP && !wr_q) begin
                ext_move_rdata_o <= ram_rdata;
            end else if (rd_pipe_q[2]) begin
                ext_move_rdata_o <= data_sync;
            end
        end
    end

    // Pin steering; the pad applies open-drain or push-pull itself
    logic [7:0] p4_out_d, p5_out_d, p6_out_d, p7_out_d;
    logic [7:0] p4_oe_d, p5_oe_d, p6_oe_d, p7_oe_d;
    logic       strobe;

    assign strobe = state_q == ST_STROBE;

    always_comb begin
        p4_out_d = p4_latch_i;
        p5_out_d = p5_latch_i;
        p6_out_d = p6_latch_i;
        p7_out_d = p7_latch_i;
        p4_oe_d  = 8'hFF;
        p5_oe_d  = 8'hFF;
        p6_oe_d  = 8'hFF;
        p7_oe_d  = 8'hFF;
        if (claim) begin
            p4_out_d[EMP_P4_WR_BIT] = !(strobe && wr_q);
            p4_out_d[EMP_P4_RD_BIT] = !(strobe && !wr_q);
            p7_oe_d = wr_q ? 8'hFF : 8'h00;
            if (muxed) begin
                p4_out_d[EMP_P4_ALE_BIT] = state_q == ST_ALEH;
                if (drive_hi_q) begin
                    p6_out_d = addr_q[15:8];
                end
                if (state_q inside {ST_START, ST_ALEH}) begin
                    p7_out_d = addr_q[7:0];
                    p7_oe_d  = 8'hFF;
                end else begin
                    p7_out_d = wdata_q;
                end
            end else begin
                if (drive_hi_q) begin
                    p5_out_d = addr_q[15:8];
                end
                p6_out_d = addr_q[7:0];
                p7_out_d = wdata_q;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            p4_out_o <= 8'hFF;
            p5_out_o <= 8'hFF;
            p6_out_o <= 8'hFF;
            p7_out_o <= 8'hFF;
            p4_oe_o  <= 8'h00;
            p5_oe_o  <= 8'h00;
            p6_oe_o  <= 8'h00;
            p7_oe_o  <= 8'h00;
        end else begin
            p4_out_o <= p4_out_d;
            p5_out_o <= p5_out_d;
            p6_out_o <= p6_out_d;
            p7_out_o <= p7_out_d;
            p4_oe_o  <= p4_oe_d;
            p5_oe_o  <= p5_oe_d;
            p6_oe_o  <= p6_oe_d;
            p7_oe_o  <= p7_oe_d;
        end
    end

    // Checking helpers
    logic [7:0] busy_cnt_q;
    logic [3:0] ale_cnt_q;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_cnt_q <= 8'h00;
            ale_cnt_q  <= 4'h0;
        end else begin
            busy_cnt_q <= active ? busy_cnt_q + 8'h01 : 8'h00;
            ale_cnt_q  <= (state_q == ST_ALEH) ? ale_cnt_q + 4'h1 : 4'h0;
        end
    end

    AST_ONCHIP_ONLY: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        start && mode == EMP_MODE_INTERNAL |=> state_q == ST_ONCHIP ##1 ext_move_done_o)
        else $error("internal mode access left the chip");

    AST_SPLIT_BELOW: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        start && (mode inside {EMP_MODE_SPLIT, EMP_MODE_BANK})
        |=> (state_q == ST_ONCHIP) == ($past(eff_addr) < EMP_ONCHIP_LIMIT))
        else $error("split mode routed wrongly");

    AST_ALE_WIDTH: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        state_q == ST_ALEH ##1 state_q != ST_ALEH |-> ale_cnt_q == $past(ale_len) + 4'h1)
        else $error("latch strobe high width wrong");

    AST_OFFCHIP_TIME: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        !muxed && state_q == ST_END && cnt_q == 4'h0 |->
        busy_cnt_q + 8'h01 == 8'(setup_len) + 8'(width_len) + 8'h01
                              + 8'(hold_len) + 8'(EMP_OVERHEAD_CYC))
        else $error("off-chip access length wrong");

    AST_READ_NO_DRIVE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        claim && !wr_q && strobe |=> p7_oe_o == 8'h00)
        else $error("data pins driven during read");

    AST_RELEASE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        !claim |=> p6_out_o == $past(p6_latch_i) && p4_out_o == $past(p4_latch_i))
        else $error("pins held outside an access");

    AST_NO_BANK_UPPER: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        claim && !drive_hi_q && !muxed |=> p5_out_o == $past(p5_latch_i))
        else $error("upper address driven without bank select");

    AST_BANK_UPPER: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        start && off_chip && mode == EMP_MODE_BANK && !ext_move_wide_i && pin_map && !muxed
        ##1 claim |=> p5_out_o == $past(addr_q[15:8]) && p6_out_o == $past(addr_q[7:0]))
        else $error("bank select address not driven");

    AST_MUX_ADDR: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        claim && muxed && state_q == ST_ALEH |=> p7_out_o == $past(addr_q[7:0])
        && p4_out_o[EMP_P4_ALE_BIT] && p7_oe_o == 8'hFF)
        else $error("low address not presented under strobe");

endmodule

// >>> dv/emp_sram_model.sv
`timescale 1ns/1ps
module emp_sram_model (
    // Clock and board wiring
    input  wire logic       mclk_i,
    input  wire logic       mux_i,
    // Device pins
    input  wire logic [7:0] p4_out_i,
    input  wire logic [7:0] p5_out_i,
    input  wire logic [7:0] p6_out_i,
    input  wire logic [7:0] p7_out_i,
    // Memory data drive
    output logic      [7:0] data_o
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  lo_q;
    logic [7:0]  last_q = 8'h00;
    logic [15:0] addr;
    logic        drive;
    int          n_wr = 0;
    int          n_rd = 0;

    // Low address taken every cycle the strobe is high, held after it falls
    always @(posedge mclk_i) begin
        if (mux_i && p4_out_i[5] === 1'b1) begin
            lo_q <= p7_out_i;
        end
    end

    assign addr = mux_i ? {p6_out_i, lo_q} : {p5_out_i, p6_out_i};
    assign drive = (p4_out_i[6] === 1'b0);
    // Released bus toggles so a stale value never passes
    assign data_o = drive ? mem[addr] : ~last_q;

    always @(posedge mclk_i) begin
        last_q <= data_o;
        if (p4_out_i[7] === 1'b0) begin
            mem[addr] <= p7_out_i;
        end
    end

    always @(negedge p4_out_i[6]) n_rd++;
    always @(negedge p4_out_i[7]) n_wr++;
endmodule

// >>> dv/emp_port_modes_tb.sv
`timescale 1ns/1ps
module emp_port_modes_tb;
    import emp_pkg::*;
    logic        mclk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [7:0]  reg_rdata_o;
    logic        ext_move_req_i = 1'b0;
    logic        ext_move_wr_i = 1'b0;
    logic        ext_move_wide_i = 1'b0;
    logic [15:0] wide_pointer_i = 16'h0000;
    logic [7:0]  index_register_i = 8'h00;
    logic [7:0]  ext_move_wdata_i = 8'h00;
    logic [7:0]  ext_move_rdata_o;
    logic        ext_move_done_o;
    logic [7:0]  hi_lat = 8'hFF;
    logic [7:0]  p7_pin_i;
    logic [7:0]  sram_data;
    logic [7:0]  p4_out_o, p4_oe_o, p5_out_o, p5_oe_o, p6_out_o, p6_oe_o, p7_out_o, p7_oe_o;
    logic        cur_mux = 1'b0;
    logic [7:0]  onref [int];
    logic [7:0]  offref [int];
    int          fails = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          seed = 80;

    always #12.5 mclk_i = ~mclk_i;
    assign p7_pin_i = (p7_oe_o & p7_out_o) | (~p7_oe_o & sram_data);

    emp_port_modes dut (.mclk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .ext_move_req_i, .ext_move_wr_i, .ext_move_wide_i, .wide_pointer_i,
        .index_register_i, .ext_move_wdata_i, .ext_move_rdata_o, .ext_move_done_o,
        .p4_latch_i(8'hFF), .p5_latch_i(hi_lat), .p6_latch_i(hi_lat), .p7_latch_i(8'hFF),
        .p7_pin_i, .p4_out_o, .p4_oe_o, .p5_out_o, .p5_oe_o, .p6_out_o, .p6_oe_o, .p7_out_o,
        .p7_oe_o);
    emp_sram_model sram (.mclk_i, .mux_i(cur_mux), .p4_out_i(p4_out_o), .p5_out_i(p5_out_o),
        .p6_out_i(p6_out_o), .p7_out_i(p7_out_o), .data_o(sram_data));

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_num(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            fails++;
            $display("MISMATCH t=%0t count got %0d exp %0d", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk_byte(reg_rdata_o, exp);
    endtask

    task automatic access(input logic wr, input logic wide, input logic [15:0] ptr,
                          input logic [7:0] idx, input logic [7:0] wd, input bit off,
                          output int lat);
        @(posedge mclk_i);
        ext_move_req_i <= 1'b1;
        ext_move_wr_i <= wr;
        ext_move_wide_i <= wide;
        wide_pointer_i <= ptr;
        index_register_i <= idx;
        ext_move_wdata_i <= wd;
        @(posedge mclk_i);
        ext_move_req_i <= 1'b0;
        lat = 0;
        do begin
            @(posedge mclk_i);
            lat++;
            // Request mid-access must be dropped
            ext_move_req_i <= (off && lat == 3);
            #1;
            if (cur_mux) chk_byte(p5_out_o, hi_lat);
            if (p4_out_o[6] === 1'b0) chk_byte(p7_oe_o, 8'h00);
        end while (ext_move_done_o !== 1'b1 && lat < 200);
    endtask

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    initial begin
        logic [7:0]  tim, page, idx, wd, hl, cfg;
        logic [15:0] ptr, ea, xa;
        int          lat, mode, exp_lat, nw, nr;
        bit          wide, mux, pm, off;
        repeat (6) @(posedge mclk_i);
        resetn_i <= 1'b1;
        reg_chk(EMP_REG_CFG, EMP_CFG_RST);
        reg_chk(EMP_REG_TIMING, EMP_TIMING_RST);
        reg_chk(EMP_REG_PAGE, EMP_PAGE_RST);
        reg_chk(EMP_REG_STATUS, 8'h00);
        reg_chk(8'h55, 8'h00);
        reg_wr(EMP_REG_CFG, 8'hFF);
        reg_chk(EMP_REG_CFG, EMP_CFG_WMASK);
        for (int c = 0; c < 18; c++) begin
            mode = (c >= 16) ? 3 : c % 4;
            mux = ((c / 4) % 2) == 1;
            wide = ((c / 8) % 2) == 1;
            pm = c < 16;
            for (int k = 0; k < 3; k++) begin
                tim = 8'($random(seed));
                page = 8'($random(seed));
                ptr = 16'($random(seed));
                idx = 8'($random(seed));
                wd = 8'($random(seed));
                hl = 8'($random(seed));
                if (k == 0) begin
                    page[7:4] = 4'h0;
                    ptr[15:12] = 4'h0;
                end
                cfg = {2'b00, pm, ~mux, 2'(mode), 2'($random(seed))};
                reg_wr(EMP_REG_PAGE, page);
                reg_wr(EMP_REG_TIMING, tim);
                reg_wr(EMP_REG_CFG, cfg);
                cur_mux <= mux;
                hi_lat <= hl;
                ea = wide ? ptr : {page, idx};
                off = (mode == 3) || (mode != 0 && ea >= EMP_ONCHIP_LIMIT);
                xa = (wide || mode == 2) ? ea : {hl, idx};
                exp_lat = off ? 5 + tim[7:6] + tim[5:2] + tim[1:0]
                              + (mux ? 2 * (cfg[1:0] + 1) : 0) : 1;
                nw = sram.n_wr;
                nr = sram.n_rd;
                access(1'b1, wide, ptr, idx, wd, off, lat);
                chk_num(lat, exp_lat);
                chk_num(sram.n_wr - nw, int'(off && pm));
                if (off && pm) chk_byte(sram.mem[xa], wd);
                if (!off) onref[ea[11:0]] = wd;
                else if (pm) offref[xa] = wd;
                // Alias through the upper nibble in internal-only mode
                if (mode == 0) ptr = ptr ^ 16'hA000;
                ea = wide ? ptr : {page, idx};
                access(1'b0, wide, ptr, idx, 8'h00, off, lat);
                chk_num(lat, exp_lat);
                chk_num(sram.n_rd - nr, int'(off && pm));
                if (!off) chk_byte(ext_move_rdata_o, onref[ea[11:0]]);
                else if (pm) chk_byte(ext_move_rdata_o, offref[xa]);
                reg_chk(EMP_REG_STATUS, {6'h00, off, 1'b0});
                chk_byte(p6_out_o, hl);
                chk_byte(p6_oe_o, 8'hFF);
                chk_byte(p4_oe_o & p5_oe_o & p7_oe_o, 8'hFF);
            end
        end
        tally_and_finish();
    end
endmodule
